// ---- rtl/mie_pkg.sv ----
// shared constants for the instruction execute block
// assumes a 14-bit instruction word and an 8-bit data path
package mie_pkg;

  localparam int INSN_W   = 14;
  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 7;
  localparam int PC_W     = 12;

  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [5:0]  OP_INC_SKIP   = 6'h0F;
  localparam logic [5:0]  OP_OR_FILE    = 6'h04;
  localparam logic [5:0]  OP_LOAD_FILE  = 6'h08;
  localparam logic [5:0]  OP_ROT_LEFT   = 6'h0D;
  localparam logic [5:0]  OP_ROT_RIGHT  = 6'h0C;
  localparam logic [5:0]  OP_SUB_FILE   = 6'h02;
  localparam logic [5:0]  OP_SWAP       = 6'h0E;
  localparam logic [5:0]  OP_OR_LIT     = 6'h1A;
  localparam logic [5:0]  OP_LOAD_LIT   = 6'h19;
  localparam logic [5:0]  OP_EXIT_LIT   = 6'h18;
  localparam logic [13:0] OP_IDLE       = 14'h0000;
  localparam logic [13:0] OP_SUB_EXIT   = 14'h0040;
  localparam logic [13:0] OP_IRQ_EXIT   = 14'h0060;
  localparam logic [13:0] OP_SLEEP      = 14'h0003;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT    = 7;
  localparam int STORE_BIT   = 7;
  localparam int LOW_FILE_W  = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [11:0] PC_RST   = 12'h000;

  typedef enum logic [1:0] {
    MIE_EXEC,
    MIE_FLUSH,
    MIE_STANDBY
  } mie_state_e;

endpackage

// ---- rtl/mie_alu.sv ----
// 8-bit arithmetic and logic unit for the execute block
// assumes opcode class is decoded by the caller
`timescale 1ns/1ns
module mie_alu
  import mie_pkg::*;
(
  // operands
  input  wire logic [5:0] op_class,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] file_val,
  input  wire logic [7:0] literal,
  input  wire logic       carry_in,
  // results
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            half_out
);

  logic [8:0] diff;
  logic [4:0] half_diff;

  // f - acc as f + ~acc + 1, carry means no borrow
  assign diff      = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
  assign half_diff = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  always_comb begin
    result    = file_val;
    carry_out = carry_in;
    half_out  = 1'b0;
    case (op_class)
      OP_INC_SKIP:  result = file_val + 8'h01;
      OP_OR_FILE:   result = acc | file_val;
      OP_OR_LIT:    result = acc | literal;
      OP_LOAD_LIT,
      OP_EXIT_LIT:  result = literal;
      OP_ROT_LEFT: begin
        result    = {file_val[6:0], carry_in};
        carry_out = file_val[7];
      end
      OP_ROT_RIGHT: begin
        result    = {carry_in, file_val[7:1]};
        carry_out = file_val[0];
      end
      OP_SUB_FILE: begin
        result    = diff[7:0];
        carry_out = diff[8];
        half_out  = half_diff[4];
      end
      OP_SWAP:      result = {file_val[3:0], file_val[7:4]};
      default:      result = file_val;
    endcase
  end

endmodule

// ---- rtl/mie_decode.sv ----
// opcode classifier for the execute block
// assumes a full 14-bit instruction word at its input
`timescale 1ns/1ns
module mie_decode
  import mie_pkg::*;
(
  // instruction
  input  wire logic [13:0] insn,
  // classification
  output logic      [5:0]  op_class,
  output logic             is_file_op,
  output logic             is_store,
  output logic             is_store_low,
  output logic             is_idle,
  output logic             is_return,
  output logic             is_irq_return,
  output logic             is_sleep,
  output logic             is_lit_op
);

  always_comb begin
    op_class      = insn[13:8];
    is_idle       = (insn == OP_IDLE);
    is_return     = (insn == OP_SUB_EXIT) || (insn == OP_IRQ_EXIT) ||
                    (insn[13:8] == OP_EXIT_LIT);
    is_irq_return = (insn == OP_IRQ_EXIT);
    is_sleep      = (insn == OP_SLEEP);
    is_store      = (insn[13:8] == 6'h00) && insn[STORE_BIT];
    is_store_low  = (insn[13:6] == 8'h00) && !is_idle && !is_sleep;
    is_lit_op     = (insn[13:8] == OP_OR_LIT) || (insn[13:8] == OP_LOAD_LIT) ||
                    (insn[13:8] == OP_EXIT_LIT);
    is_file_op    = (insn[13:8] == OP_INC_SKIP) || (insn[13:8] == OP_OR_FILE) ||
                    (insn[13:8] == OP_ROT_LEFT) || (insn[13:8] == OP_ROT_RIGHT) ||
                    (insn[13:8] == OP_SUB_FILE) || (insn[13:8] == OP_SWAP) ||
                    ((insn[13:8] == OP_LOAD_FILE) && !insn[DEST_BIT]);
  end

endmodule

// ---- rtl/mie_core.sv ----
// execute stage for a subset of a 14-bit instruction set
// assumes program memory returns insn for pc in the same cycle and the
// register file gives a combinational read at file_addr
// assumes standby is left only through wake
`timescale 1ns/1ns
module mie_core
  import mie_pkg::*;
#(
  parameter int ADDR_W = FADDR_W
)
(
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  // program memory
  output logic      [mie_pkg::PC_W-1:0]     pc,
  input  wire logic [mie_pkg::INSN_W-1:0]   insn,
  // register file
  output logic      [ADDR_W-1:0]            file_addr,
  input  wire logic [mie_pkg::DATA_W-1:0]   file_rdata,
  output logic                              file_we,
  output logic      [mie_pkg::DATA_W-1:0]   file_wdata,
  // return stack
  input  wire logic [mie_pkg::PC_W-1:0]     stack_top,
  output logic                              stack_pop,
  // flags and state
  output logic      [mie_pkg::DATA_W-1:0]   acc,
  output logic                              carry_flag,
  output logic                              half_borrow_flag,
  output logic                              zero_flag,
  output logic                              global_irq_enable,
  output logic                              timeout_flag,
  output logic                              powerdown_flag,
  output logic                              standby,
  // wake from standby
  input  wire logic                         wake
);

  import mie_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // next sequential fetch address
  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] p);
    return p + 12'h001;
  endfunction

  // all-zero byte test shared by skip and zero flag
  function automatic logic byte_zero(input logic [DATA_W-1:0] b);
    return (b == 8'h00);
  endfunction

  // classes that write the carry flag
  function automatic logic writes_carry(input logic [5:0] cls);
    return (cls == OP_ROT_LEFT) || (cls == OP_ROT_RIGHT) || (cls == OP_SUB_FILE);
  endfunction

  // classes that write the zero flag
  function automatic logic writes_zero(input logic [5:0] cls);
    return (cls == OP_OR_FILE) || (cls == OP_SUB_FILE) || (cls == OP_OR_LIT);
  endfunction

  // classes that write the half borrow flag
  function automatic logic writes_half(input logic [5:0] cls);
    return (cls == OP_SUB_FILE);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [5:0] op_class;
  logic       is_file_op;
  logic       is_store;
  logic       is_store_low;
  logic       is_idle;
  logic       is_return;
  logic       is_irq_return;
  logic       is_sleep;
  logic       is_lit_op;

  mie_decode u_decode (
    .insn          (insn),
    .op_class      (op_class),
    .is_file_op    (is_file_op),
    .is_store      (is_store),
    .is_store_low  (is_store_low),
    .is_idle       (is_idle),
    .is_return     (is_return),
    .is_irq_return (is_irq_return),
    .is_sleep      (is_sleep),
    .is_lit_op     (is_lit_op)
  );

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  logic [7:0] alu_result;
  logic       alu_carry;
  logic       alu_half;

  mie_alu u_alu (
    .op_class  (op_class),
    .acc       (acc),
    .file_val  (file_rdata),
    .literal   (insn[7:0]),
    .carry_in  (carry_flag),
    .result    (alu_result),
    .carry_out (alu_carry),
    .half_out  (alu_half)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  mie_state_e state_reg;
  mie_state_e state_next;
  logic       exec;
  logic       to_acc;
  logic       to_file;
  logic       skip;
  logic       zero_upd;
  logic       skip_hold;

  // flush slot: a skip moves pc over the dead word,
  // a return holds pc at the popped address
  assign exec = (state_reg == MIE_EXEC);

  always_comb begin
    to_acc   = 1'b0;
    to_file  = 1'b0;
    zero_upd = 1'b0;
    if (exec && is_file_op) begin
      if (op_class == OP_LOAD_FILE)
        to_acc = 1'b1;
      else if (insn[DEST_BIT])
        to_file = 1'b1;
      else
        to_acc = 1'b1;
      zero_upd = writes_zero(op_class);
    end else if (exec && is_lit_op) begin
      to_acc   = 1'b1;
      zero_upd = writes_zero(op_class);
    end
  end

  // zero increment result turns next slot into a flush
  assign skip = exec && (op_class == OP_INC_SKIP) && byte_zero(alu_result);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MIE_EXEC: begin
        if (is_sleep)
          state_next = MIE_STANDBY;
        else if (is_return || skip)
          state_next = MIE_FLUSH;
        else
          state_next = MIE_EXEC;
      end
      MIE_FLUSH:   state_next = MIE_EXEC;
      MIE_STANDBY: begin
        if (wake)
          state_next = MIE_EXEC;
      end
      default:     state_next = MIE_EXEC;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      state_reg <= MIE_EXEC;
    else
      state_reg <= state_next;
  end

  assign standby = (state_reg == MIE_STANDBY);

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  assign stack_pop = exec && is_return;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      pc <= PC_RST;
    else if (stack_pop)
      pc <= stack_top;
    else if (exec && !is_sleep)
      pc <= pc_step(pc);
    else if (state_reg == MIE_FLUSH && skip_hold)
      pc <= pc_step(pc);
    // wake resumes past the sleep word
    else if (standby && wake)
      pc <= pc_step(pc);
  end

  // remember that the flush skips a slot rather than waits on a pop

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      skip_hold <= 1'b0;
    else
      skip_hold <= skip;
  end

  // ----------------------------------------------------------------
  // register file port
  // ----------------------------------------------------------------
  always_comb begin
    file_addr = insn[ADDR_W-1:0];
    if (is_store_low)
      file_addr = {{(ADDR_W-LOW_FILE_W){1'b0}}, insn[LOW_FILE_W-1:0]};
  end

  // stores take acc, everything else the alu result
  assign file_we    = exec && (to_file || is_store || is_store_low);
  assign file_wdata = (is_store || is_store_low) ? acc : alu_result;

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      acc <= ACC_RST;
    else if (to_acc)
      acc <= alu_result;
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // flags hold through flush and standby
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      zero_flag <= 1'b0;
    else if (zero_upd)
      zero_flag <= byte_zero(alu_result);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      carry_flag <= 1'b0;
    else if (exec && is_file_op && writes_carry(op_class))
      carry_flag <= alu_carry;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      half_borrow_flag <= 1'b0;
    else if (exec && is_file_op && writes_half(op_class))
      half_borrow_flag <= alu_half;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      global_irq_enable <= 1'b0;
    else if (exec && is_irq_return)
      global_irq_enable <= 1'b1;
  end

  // sleep: timeout flag set, powerdown flag cleared (active-low sense)
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      timeout_flag <= 1'b1;
    else if (exec && is_sleep)
      timeout_flag <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      powerdown_flag <= 1'b1;
    else if (exec && is_sleep)
      powerdown_flag <= 1'b0;
  end

endmodule

// ---- testbench/mie_core_assertions.sv ----
// concurrent checks on the execute block ports
// bound to mie_core from the bench top file
`timescale 1ns/1ns
module mie_core_chk
  import mie_pkg::*;
#(
  parameter int ADDR_W = FADDR_W
)
(
  // ports of mie_core, all watched except carry_flag, half_borrow_flag and wake
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic [PC_W-1:0]   pc,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic              file_we,
  input wire logic [DATA_W-1:0] file_wdata,
  input wire logic [PC_W-1:0]   stack_top,
  input wire logic              stack_pop,
  input wire logic [DATA_W-1:0] acc,
  input wire logic              carry_flag,
  input wire logic              half_borrow_flag,
  input wire logic              zero_flag,
  input wire logic              global_irq_enable,
  input wire logic              timeout_flag,
  input wire logic              powerdown_flag,
  input wire logic              standby,
  input wire logic              wake
);
  logic       flush_reg;
  logic       exec;
  logic       inc_op;
  logic       ret_op;
  logic [7:0] lit;
  assign exec   = !flush_reg && !standby;
  assign inc_op = insn[13:8] == OP_INC_SKIP;
  assign ret_op = insn == OP_SUB_EXIT || insn == OP_IRQ_EXIT || insn[13:8] == OP_EXIT_LIT;
  assign lit    = insn[7:0];
  // marks the dead second slot
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= exec && (ret_op || (inc_op && file_rdata == 8'hFF));
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_flush_quiet: assert property (flush_reg |-> (!file_we && !stack_pop) ##1 ($stable(acc) && $stable(zero_flag)))
    else $error("write during second slot");
  chk_ret_pop: assert property (exec && ret_op |-> stack_pop ##1 pc == $past(stack_top))
    else $error("return did not reload pc");
  chk_irq_enable: assert property (exec && insn == OP_IRQ_EXIT |=> global_irq_enable)
    else $error("irq enable not set");
  chk_lit_load: assert property (exec && insn[13:8] == OP_LOAD_LIT |=> acc == $past(lit))
    else $error("literal not loaded");
  chk_or_lit: assert property (exec && insn[13:8] == OP_OR_LIT |=> acc == ($past(acc) | $past(lit)) && zero_flag == (acc == 8'h00))
    else $error("or literal wrong");
  chk_store_full: assert property (exec && insn[13:7] == 7'h01 |-> file_we && file_wdata == acc && file_addr == insn[6:0])
    else $error("store wrong");
  chk_store_low: assert property (exec && insn[13:6] == 8'h00 && insn[5:0] > 6'h03 |-> file_we && file_addr == {1'b0, insn[5:0]})
    else $error("low store wrong");
  chk_inc_dest: assert property (exec && inc_op && insn[7] |-> file_we && file_wdata == file_rdata + 8'h01)
    else $error("increment write wrong");
  chk_inc_skip: assert property (exec && inc_op && file_rdata == 8'hFF |=> pc == $past(pc) + 12'h001 ##1 pc == $past(pc, 2) + 12'h002)
    else $error("skip pc wrong");
  chk_inc_run: assert property (exec && inc_op && file_rdata != 8'hFF |=> pc == $past(pc) + 12'h001 && !flush_reg)
    else $error("run pc wrong");
  chk_sleep_flags: assert property (exec && insn == OP_SLEEP |=> standby && timeout_flag && !powerdown_flag && $stable(pc))
    else $error("sleep state wrong");
  cover property (exec && inc_op && file_rdata == 8'hFF);
  cover property (exec && insn == OP_IRQ_EXIT);
  cover property (exec && insn == OP_SLEEP);
endmodule

// ---- testbench/mie_core_tb.sv ----
// self-checking bench for mie_core
// bench acts as program memory, register file and return stack
`timescale 1ns/1ns
module mie_core_tb;
  import mie_pkg::*;
  localparam logic [5:0]  OPS [10] = '{OP_INC_SKIP, OP_OR_FILE, OP_LOAD_FILE, OP_ROT_LEFT, OP_ROT_RIGHT,
                                       OP_SUB_FILE, OP_SWAP, OP_OR_LIT, OP_LOAD_LIT, OP_EXIT_LIT};
  localparam logic [13:0] DIR [20] = '{14'h0F90, 14'h0F10, 14'h0F7F, 14'h1902, 14'h02A0, 14'h02A1, 14'h02A2,
                                       14'h199A, 14'h1A35, 14'h04A0, 14'h0830, 14'h0D30, 14'h0CB0, 14'h0E30,
                                       14'h00FF, 14'h003F, 14'h0040, 14'h0060, 14'h18C3, 14'h0000};
  logic        clk_sys, rstn, file_we, stack_pop, wake, carry_flag, half_borrow_flag, zero_flag;
  logic        global_irq_enable, timeout_flag, powerdown_flag, standby;
  logic        m_c, m_dc, m_z, m_gie, m_to, m_pd, m_sb;
  logic [11:0] pc, stack_top, m_pc;
  logic [13:0] insn;
  logic [6:0]  file_addr;
  logic [7:0]  file_rdata, file_wdata, acc, m_acc;
  logic [7:0]  rf [128];
  logic [7:0]  m_rf [128];
  logic [26:0] note_q [$];
  logic [26:0] seen;
  int          err_total;
  int          check_count;

  mie_core uut (.clk_sys(clk_sys), .rstn(rstn), .pc(pc), .insn(insn), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata), .stack_top(stack_top),
    .stack_pop(stack_pop), .acc(acc), .carry_flag(carry_flag), .half_borrow_flag(half_borrow_flag),
    .zero_flag(zero_flag), .global_irq_enable(global_irq_enable), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .standby(standby), .wake(wake));

  assign file_rdata = rf[file_addr];
  assign seen = {pc, acc, carry_flag, half_borrow_flag, zero_flag, global_irq_enable, timeout_flag,
                 powerdown_flag, standby};
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (file_we) rf[file_addr] <= file_wdata;

  task automatic check(input string what, input logic [26:0] got, input logic [26:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic push();
    note_q.push_back({m_pc, m_acc, m_c, m_dc, m_z, m_gie, m_to, m_pd, m_sb});
  endtask

  // ------------------------------------------------------------
  // scoreboard side
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (note_q.size() > 0) begin
      check("state", seen, note_q.pop_front());
    end
  end

  task automatic do_reset();
    #10;
    rstn = 1'b0;
    repeat (20) @(negedge clk_sys);
    check("reset", seen, 27'h000_0006);
    {m_pc, m_acc, m_c, m_dc, m_z, m_gie, m_to, m_pd, m_sb} = 27'h000_0006;
    rstn = 1'b1;
  endtask

  // one instruction, entered and left at a falling edge
  task automatic step(input logic [13:0] w);
    logic [7:0] v;
    logic [7:0] r;
    logic [8:0] s;
    logic       fop;
    logic       two;
    v = m_rf[w[6:0]];
    r = v;
    fop = 1'b1;
    two = 1'b0;
    insn = w;
    stack_top = 12'($urandom);
    @(posedge clk_sys);
    case (w[13:8])
      OP_INC_SKIP:  r = v + 8'h01;
      OP_OR_FILE:   r = v | m_acc;
      OP_ROT_LEFT:  {m_c, r} = {v, m_c};
      OP_ROT_RIGHT: {r, m_c} = {m_c, v};
      OP_SWAP:      r = {v[3:0], v[7:4]};
      OP_LOAD_FILE: r = v;
      OP_SUB_FILE: begin
        s = {1'b0, v} - {1'b0, m_acc};
        r = s[7:0];
        m_c = ~s[8];
        m_dc = v[3:0] >= m_acc[3:0];
      end
      6'h00: begin
        fop = 1'b0;
        two = w == OP_SUB_EXIT || w == OP_IRQ_EXIT;
        m_gie = m_gie | (w == OP_IRQ_EXIT);
        if (w[7]) m_rf[w[6:0]] = m_acc;
        else if (w[6:0] != 7'h00 && !two) m_rf[{1'b0, w[5:0]}] = m_acc;
      end
      default: begin
        fop = 1'b0;
        two = w[13:8] == OP_EXIT_LIT;
        m_acc = (w[13:8] == OP_OR_LIT) ? (m_acc | w[7:0]) : w[7:0];
        m_z = (w[13:8] == OP_OR_LIT) ? (m_acc == 8'h00) : m_z;
      end
    endcase
    if (w[13:8] == OP_OR_FILE || w[13:8] == OP_SUB_FILE) m_z = r == 8'h00;
    if (fop && w[7]) m_rf[w[6:0]] = r;
    if (fop && !w[7]) m_acc = r;
    m_pc = two ? stack_top : m_pc + 12'h001;
    push();
    @(negedge clk_sys);
    if (two || (w[13:8] == OP_INC_SKIP && r == 8'h00)) begin
      insn = {7'h01, 7'($urandom)}; // dead slot offers a store
      @(posedge clk_sys);
      m_pc = two ? m_pc : m_pc + 12'h001;
      push();
      @(negedge clk_sys);
    end
  endtask

  function automatic logic [13:0] rnd_word();
    logic [13:0] w;
    int          sel;
    w = 14'($urandom);
    sel = $urandom % 15;
    if (sel < 10) w[13:8] = OPS[sel];
    if (sel < 10 && OPS[sel] == OP_LOAD_FILE) w[7] = 1'b0;
    if (sel == 10) w = OP_IDLE;
    if (sel == 11) w = OP_SUB_EXIT;
    if (sel == 12) w = OP_IRQ_EXIT;
    if (sel == 13) w[13:7] = 7'h01;
    if (sel == 14) w = {8'h00, (w[5:0] < 6'h04) ? 6'h3F : w[5:0]};
    return w;
  endfunction

  task automatic nap();
    insn = OP_SLEEP;
    @(posedge clk_sys);
    {m_to, m_pd, m_sb} = 3'h5;
    push();
    @(negedge clk_sys);
    insn = {OP_LOAD_LIT, 8'h5A};
    @(posedge clk_sys);
    push();
    @(negedge clk_sys);
    insn = OP_IDLE;
    wake = 1'b1;
    @(posedge clk_sys);
    m_pc = m_pc + 12'h001;
    m_sb = 1'b0;
    push();
    @(negedge clk_sys);
    wake = 1'b0;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    void'($urandom(21637));
    clk_sys = 1'b0;
    rstn = 1'b0;
    wake = 1'b0;
    insn = OP_IDLE;
    stack_top = 12'h000;
    err_total = 0;
    check_count = 0;
    foreach (rf[i]) rf[i] = 8'($urandom);
    {rf[16], rf[32], rf[33], rf[34], rf[48], rf[127]} = 48'hFF03_0201_E6FF;
    m_rf = rf;
    do_reset();
    foreach (DIR[i]) step(DIR[i]);
    repeat (400) step(rnd_word());
    nap();
    do_reset();
    repeat (40) step(rnd_word());
    @(negedge clk_sys);
    foreach (rf[i]) check("file", {19'h0_0000, rf[i]}, {19'h0_0000, m_rf[i]});
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    print_verdict();
  end
endmodule

bind mie_core mie_core_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_sys(clk_sys), .rstn(rstn), .pc(pc), .insn(insn),
  .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata),
  .stack_top(stack_top), .stack_pop(stack_pop), .acc(acc), .carry_flag(carry_flag),
  .half_borrow_flag(half_borrow_flag), .zero_flag(zero_flag), .global_irq_enable(global_irq_enable),
  .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .standby(standby), .wake(wake));
